// File: status_cfg_map.vh
// register offsets, field positions, reset values and timing for the status/config bank
`ifndef STATUS_CFG_MAP_VH
`define STATUS_CFG_MAP_VH
`define SYSTEM_STATUS_ADDR 8'h00
`define GENERAL_CONFIG_ADDR 8'h01
`define SYSTEM_STATUS_RESET 8'h81
`define GENERAL_CONFIG_RESET 8'h00
`define ST_FIXED_ONE 7
`define ST_SEQ_RUN 6
`define ST_HS_MODE 5
`define ST_AVG_DONE 3
`define ST_FUSE_ERR 2
`define ST_CRC_ERR 1
`define ST_BROWNOUT 0
`define CFG_CRC_EN 6
`define CFG_STATISTICS_ENABLE 5
`define CFG_WRITE_MASK 8'h76
`define CFG_SOFT_RESET 0
`define SRST_CYCLES 8'h0a
`endif

// File: sync2.v
// two-flop synchroniser for a level input
`timescale 1ns/100ps
`default_nettype none
module sync2 (
  // clock and reset
  input wire mclk,
  input wire rst,
  // level in and out
  input wire d,
  output reg q
);
  reg meta_reg;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// File: status_cfg_regs.v
// system status and general configuration register pair
//
// What this block does
// - status resets 0x81, top bit reads one
// - bit 6 shows sequencer running, read-only
// - bit 5 shows high-speed bus mode, read-only
// - averaging done flag sets, write-one clears
// - fuse error flag read-only, sampled at reset
// - crc error blocks writes except 0x00, 0x01
// - bad frame sets crc error only when crc enable is set; host clears
// - brown-out flag resets one, write-one clears
// - config resets zero, bit 7 reads zero
// - crc enable drives append and check
// - statistics enable clears then updates stats
// - soft reset ends: bit clears, brown-out sets
`timescale 1ns/100ps
`default_nettype none
`include "status_cfg_map.vh"
module status_cfg_regs (
  // clock and reset
  input wire mclk,
  input wire rst,
  // register access from the serial front end
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] addr,
  input wire [7:0] wr_data,
  output reg [7:0] rd_data,
  output reg write_blocked,
  // device events, same clock
  input wire seq_running,
  input wire hs_mode,
  input wire avg_ready,
  input wire frame_crc_bad,
  input wire fuse_crc_bad,
  input wire brownout_event,
  // brown-out detector from the analog side
  input wire brownout_pin,
  // control outputs
  output reg crc_enable,
  output reg statistics_enable,
  output reg stats_clear,
  output reg soft_reset_active,
  output reg fuse_sample
);
  reg averaging_complete_flag_reg;
  reg crc_err_reg;
  reg brownout_flag_reg;
  reg powerup_config_integrity_error_reg;
  reg [7:0] cfg_reg;
  reg [7:0] srst_cnt_reg;
  reg fuse_pending_reg;
  reg seq_reg;
  reg hs_reg;
  wire bo_sync;
  wire [7:0] status_val;
  wire wr_status;
  wire wr_cfg;
  wire wr_other;
  wire srst_busy;
  wire srst_done;

  sync2 bo_sync_i (
    .mclk(mclk),
    .rst(rst),
    .d(brownout_pin),
    .q(bo_sync)
  );

  function wr_hit;
    input [7:0] a;
    input [7:0] target;
    begin
      wr_hit = (a == target);
    end
  endfunction

  assign wr_status = wr_en && wr_hit(addr, `SYSTEM_STATUS_ADDR);
  assign wr_cfg = wr_en && wr_hit(addr, `GENERAL_CONFIG_ADDR) && !soft_reset_active;
  assign wr_other = wr_en && !wr_hit(addr, `SYSTEM_STATUS_ADDR) &&
                    !wr_hit(addr, `GENERAL_CONFIG_ADDR);
  assign srst_busy = (srst_cnt_reg != 8'h00);
  assign srst_done = (srst_cnt_reg == 8'h01);

  assign status_val = {1'b1, seq_reg, hs_reg, 1'b0, averaging_complete_flag_reg,
                       powerup_config_integrity_error_reg, crc_err_reg, brownout_flag_reg};

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      seq_reg <= 1'b0;
      hs_reg <= 1'b0;
    end else begin
      seq_reg <= seq_running;
      hs_reg <= hs_mode;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      averaging_complete_flag_reg <= 1'b0;
    end else if (srst_busy) begin
      averaging_complete_flag_reg <= 1'b0;
    end else if (avg_ready) begin
      averaging_complete_flag_reg <= 1'b1;
    end else if (wr_status && wr_data[`ST_AVG_DONE]) begin
      averaging_complete_flag_reg <= 1'b0;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      crc_err_reg <= 1'b0;
    end else if (srst_busy) begin
      crc_err_reg <= 1'b0;
    end else if (frame_crc_bad && cfg_reg[`CFG_CRC_EN]) begin
      crc_err_reg <= 1'b1;
    end else if (wr_status && wr_data[`ST_CRC_ERR]) begin
      crc_err_reg <= 1'b0;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      brownout_flag_reg <= 1'b1;
    end else if (brownout_event || bo_sync || srst_done) begin
      brownout_flag_reg <= 1'b1;
    end else if (wr_status && wr_data[`ST_BROWNOUT]) begin
      brownout_flag_reg <= 1'b0;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      powerup_config_integrity_error_reg <= 1'b0;
      fuse_pending_reg <= 1'b1;
      fuse_sample <= 1'b0;
    end else begin
      fuse_sample <= fuse_pending_reg;
      if (fuse_pending_reg) begin
        powerup_config_integrity_error_reg <= fuse_crc_bad;
        fuse_pending_reg <= 1'b0;
      end
      // re-arm the capture as soft reset ends
      if (srst_done) begin
        fuse_pending_reg <= 1'b1;
      end
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_reg <= `GENERAL_CONFIG_RESET;
      stats_clear <= 1'b0;
    end else begin
      stats_clear <= 1'b0;
      if (srst_busy) begin
        cfg_reg <= `GENERAL_CONFIG_RESET;
      end else if (wr_cfg) begin
        // reserved bit 7 and strobe bits are not stored
        cfg_reg <= wr_data & `CFG_WRITE_MASK;
        if (wr_data[`CFG_STATISTICS_ENABLE] && !cfg_reg[`CFG_STATISTICS_ENABLE]) begin
          stats_clear <= 1'b1;
        end
      end
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      srst_cnt_reg <= 8'h00;
      soft_reset_active <= 1'b0;
    end else begin
      if (srst_busy) begin
        srst_cnt_reg <= srst_cnt_reg - 8'h01;
      end else if (wr_cfg && wr_data[`CFG_SOFT_RESET]) begin
        srst_cnt_reg <= `SRST_CYCLES;
      end
      soft_reset_active <= (srst_cnt_reg > 8'h01) ||
                           (wr_cfg && wr_data[`CFG_SOFT_RESET]);
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      write_blocked <= 1'b0;
      crc_enable <= 1'b0;
      statistics_enable <= 1'b0;
    end else begin
      write_blocked <= wr_other && crc_err_reg;
      crc_enable <= cfg_reg[`CFG_CRC_EN];
      statistics_enable <= cfg_reg[`CFG_STATISTICS_ENABLE];
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_data <= `SYSTEM_STATUS_RESET;
    end else if (rd_en) begin
      if (wr_hit(addr, `SYSTEM_STATUS_ADDR)) begin
        rd_data <= status_val;
      end else if (wr_hit(addr, `GENERAL_CONFIG_ADDR)) begin
        rd_data <= cfg_reg;
      end else begin
        rd_data <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

// File: status_cfg_properties.sv
// assertions bound to the status and config register pair
`timescale 1ns/100ps
`default_nettype none
module status_cfg_properties (
  // clock, reset and access
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  // status levels and control outputs
  input wire logic seq_running,
  input wire logic hs_mode,
  input wire logic write_blocked,
  input wire logic crc_enable,
  input wire logic statistics_enable,
  input wire logic stats_clear,
  input wire logic soft_reset_active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  status_fixed_a:
    assert property (rd_en && addr == 8'h00 |=> rd_data[7] && !rd_data[4]) else $error("fixed");
  seq_hs_a:
    assert property (rd_en && addr == 8'h00 |=> rd_data[6:5] == $past({seq_running, hs_mode}, 2))
    else $error("seq hs");
  cfg_reserved_a:
    assert property (rd_en && addr == 8'h01 |=> !rd_data[7] && !rd_data[3] && !rd_data[0])
    else $error("cfg zero bits");
  blocked_cause_a:
    assert property (write_blocked |-> $past(wr_en && addr > 8'h01)) else $error("blocked");
  cfg_copy_a:
    assert property (wr_en && addr == 8'h01 && !wr_data[0] && !soft_reset_active |=> ##1
      {crc_enable, statistics_enable} == $past(wr_data[6:5], 2)) else $error("cfg copy");
  stats_clear_a:
    assert property (stats_clear |-> $past(wr_en && addr == 8'h01 && wr_data[5]))
    else $error("stats clear");
  srst_start_a:
    assert property (wr_en && addr == 8'h01 && wr_data[0] |-> ##[1:2] soft_reset_active)
    else $error("srst start");
  srst_end_a:
    assert property ($rose(soft_reset_active) |-> ##[9:11] !soft_reset_active) else $error("srst end");
endmodule
bind status_cfg_regs status_cfg_properties status_cfg_properties_i (.*);
`default_nettype wire

// File: host_model.sv
// host side that issues single-byte register reads and writes
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // clock and access lines
  input wire logic mclk,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);
  initial {wr_en, rd_en, addr, wr_data} = 18'h0;
  // released lines show the inverse of the last value
  task wr(input logic [7:0] a, d);
    @(posedge mclk) {wr_en, addr, wr_data} <= {1'b1, a, d};
    @(posedge mclk) {wr_en, addr, wr_data} <= {1'b0, ~a, ~d};
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk) {rd_en, addr} <= {1'b1, a};
    @(posedge mclk) {rd_en, addr} <= {1'b0, ~a};
    @(posedge mclk) #1 d = rd_data;
  endtask
endmodule
`default_nettype wire

// File: tb.sv
// testbench for the status and config register pair
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic mclk = 0, rst = 1;
  logic [6:0] ev = 7'h00;
  logic [7:0] v;
  wire [7:0] addr, wr_data, rd_data;
  wire wr_en, rd_en, write_blocked, crc_enable, statistics_enable, stats_clear;
  wire soft_reset_active, fuse_sample;
  int n_fail = 0, comparisons = 0, cyc = 0, n_fuse = 0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (fuse_sample) n_fuse <= n_fuse + 1;
  host_model host_model_i (.*);
  status_cfg_regs status_cfg_regs_i (.*, .seq_running(ev[0]), .hs_mode(ev[1]), .avg_ready(ev[2]),
    .frame_crc_bad(ev[3]), .fuse_crc_bad(ev[4]), .brownout_event(ev[5]), .brownout_pin(ev[6]));
  task chk(input logic [7:0] g, e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %0t got %h want %h", $time, g, e);
    end
  endtask
  task r(input logic [7:0] a, e);
    host_model_i.rd(a, v);
    chk(v, e);
  endtask
  task w(input logic [7:0] a, d);
    host_model_i.wr(a, d);
  endtask
  task pulse(input int b);
    @(posedge mclk) ev[b] <= 1'b1;
    repeat (3) @(posedge mclk);
    ev[b] <= 1'b0;
  endtask
  task conclude;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      conclude;
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    r(8'h00, 8'h81);
    r(8'h01, 8'h00);
    w(8'h00, 8'h00);
    r(8'h00, 8'h81);
    w(8'h00, 8'hff);
    r(8'h00, 8'h80);
    @(posedge mclk) ev[1:0] <= 2'b11;
    r(8'h00, 8'he0);
    @(posedge mclk) ev[1:0] <= 2'b00;
    r(8'h00, 8'h80);
    pulse(2);
    r(8'h00, 8'h88);
    w(8'h00, 8'h08);
    r(8'h00, 8'h80);
    $display("test flags done");
    pulse(3);
    r(8'h00, 8'h80);
    w(8'h01, 8'h60);
    r(8'h01, 8'h60);
    pulse(3);
    r(8'h00, 8'h82);
    w(8'h02, 8'h55);
    #1 chk({7'h00, write_blocked}, 8'h01);
    w(8'h01, 8'h40);
    r(8'h01, 8'h40);
    w(8'h00, 8'h02);
    r(8'h00, 8'h80);
    $display("test crc done");
    @(posedge mclk) ev[4] <= 1'b1;
    w(8'h01, 8'h01);
    repeat (20) @(posedge mclk);
    r(8'h01, 8'h00);
    r(8'h00, 8'h85);
    w(8'h00, 8'h01);
    pulse(6);
    r(8'h00, 8'h85);
    w(8'h00, 8'h01);
    pulse(5);
    r(8'h00, 8'h85);
    chk(n_fuse[7:0], 8'h02);
    $display("test reset done");
    conclude;
  end
endmodule
`default_nettype wire
